// ---- dsm_consts.svh ----
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH
`define DSM_SELFTEST_NS 1000
`define DSM_CLK_NS 10
`define DSM_SELFTEST_CYC ((`DSM_SELFTEST_NS + `DSM_CLK_NS - 1) / `DSM_CLK_NS)
`define DSM_GEN_HALF_CYC 256
`define DSM_REF_RST 16'h0000
`endif

// ---- dsm_pkg.sv ----
package dsm_pkg;
  typedef enum logic [3:0] {
    ST_NOT_READY = 4'h0,
    ST_SW_DISABLED = 4'h1,
    ST_READY = 4'h2,
    ST_SWITCHED_ON = 4'h3,
    ST_OP_ENABLED = 4'h4,
    ST_QSTOP = 4'h5,
    ST_FAULT_REACT = 4'h6,
    ST_FAULT = 4'h7
  } dsm_state_t;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SHUTDOWN = 3'h1,
    CMD_SWITCH_ON = 3'h2,
    CMD_ENABLE_OP = 3'h3,
    CMD_DISABLE_OP = 3'h4,
    CMD_DISABLE_V = 3'h5,
    CMD_QUICK_STOP = 3'h6,
    CMD_FAULT_RESET = 3'h7
  } dsm_cmd_t;
  typedef enum logic [1:0] {
    SRC_ECAT = 2'h0,
    SRC_CAN = 2'h1,
    SRC_LOCAL = 2'h2,
    SRC_ANALOG = 2'h3
  } dsm_src_t;
  typedef enum logic [2:0] {
    MODE_AN_SPEED = 3'h0,
    MODE_AN_TORQUE = 3'h1,
    MODE_INT_SPEED = 3'h2,
    MODE_INT_TORQUE = 3'h3,
    MODE_CS_POS = 3'h4,
    MODE_CS_VEL = 3'h5,
    MODE_CS_TORQUE = 3'h6
  } dsm_mode_t;
  typedef enum logic [2:0] {
    SHP_SQUARE = 3'h0,
    SHP_TRIANGLE = 3'h1,
    SHP_SAWTOOTH = 3'h2,
    SHP_KEYSTONE = 3'h3,
    SHP_PROFILE = 3'h4,
    SHP_JOG = 3'h5
  } dsm_shape_t;
endpackage : dsm_pkg

// ---- dsm_cmd_sel.sv ----
`timescale 1ns/1ps
module dsm_cmd_sel import dsm_pkg::*; #(
  parameter int REF_W = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dsm_src_t src_in,
  input wire dsm_cmd_t ecat_cmd_in,
  input wire dsm_cmd_t can_cmd_in,
  input wire dsm_cmd_t io_cmd_in,
  input wire dsm_cmd_t local_cmd_in,
  input wire logic local_send_in,
  input wire logic [REF_W-1:0] ecat_ref_in,
  input wire logic [REF_W-1:0] can_ref_in,
  input wire logic [REF_W-1:0] local_ref_in,
  output dsm_cmd_t cmd_out,
  output logic send_en_out,
  output logic [REF_W-1:0] ref_out
);
  logic send_d_r;
  wire logic send_rise = local_send_in & ~send_d_r;
  assign send_en_out = (src_in == SRC_LOCAL);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      send_d_r <= 1'b0;
    end else begin
      send_d_r <= local_send_in;
    end
  end
  always_comb begin
    cmd_out = CMD_NONE;
    ref_out = '0;
    unique case (src_in)
      SRC_ECAT: begin
        cmd_out = ecat_cmd_in;
        ref_out = ecat_ref_in;
      end
      SRC_CAN: begin
        cmd_out = can_cmd_in;
        ref_out = can_ref_in;
      end
      SRC_LOCAL: begin
        cmd_out = send_rise ? local_cmd_in : CMD_NONE;
        ref_out = local_ref_in;
      end
      SRC_ANALOG: begin
        cmd_out = io_cmd_in;
      end
    endcase
  end
endmodule : dsm_cmd_sel

// ---- dsm_gen.sv ----
`timescale 1ns/1ps
`include "dsm_consts.svh"
module dsm_gen import dsm_pkg::*; #(
  parameter int REF_W = 16,
  parameter int HALF_CYC = `DSM_GEN_HALF_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire dsm_shape_t shape_in,
  input wire logic [REF_W-1:0] amp_in,
  input wire logic [REF_W-1:0] offset_in,
  output logic [REF_W-1:0] ref_out
);
  localparam int PW = $clog2(2 * HALF_CYC);
  localparam logic [REF_W-1:0] REF_RST = REF_W'(`DSM_REF_RST);
  if (HALF_CYC < 2) begin : g_bad_half
    $error("HALF_CYC too small");
  end
  logic [PW-1:0] ph_r;
  logic [REF_W-1:0] ref_r;
  logic [REF_W-1:0] ref_nxt;
  wire logic second_half = (ph_r >= PW'(HALF_CYC));
  wire logic [REF_W-1:0] ramp = REF_W'((32'(ph_r) * 32'(amp_in)) /
    (2 * HALF_CYC));
  wire logic [REF_W-1:0] tri_v = second_half ?
    REF_W'((32'(2 * HALF_CYC - 32'(ph_r)) * 32'(amp_in)) / HALF_CYC) :
    REF_W'((32'(ph_r) * 32'(amp_in)) / HALF_CYC);
  wire logic [REF_W-1:0] keys_v = (tri_v > (amp_in >> 1)) ?
    (amp_in >> 1) : tri_v;
  assign ref_out = ref_r;
  always_comb begin
    ref_nxt = offset_in;
    unique case (shape_in)
      SHP_SQUARE: ref_nxt = second_half ? offset_in : offset_in + amp_in;
      SHP_TRIANGLE: ref_nxt = offset_in + tri_v;
      SHP_SAWTOOTH: ref_nxt = offset_in + ramp;
      SHP_KEYSTONE: ref_nxt = offset_in + (keys_v << 1);
      SHP_PROFILE: ref_nxt = offset_in + (second_half ? amp_in : ramp);
      SHP_JOG: ref_nxt = offset_in + amp_in;
      default: ref_nxt = offset_in;
    endcase
    if (!run_in) ref_nxt = REF_RST;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ph_r <= '0;
      ref_r <= REF_RST;
    end else begin
      ph_r <= (!run_in || ph_r == PW'(2 * HALF_CYC - 1)) ? '0 : ph_r + 1'b1;
      ref_r <= ref_nxt;
    end
  end
endmodule : dsm_gen

// ---- dsm_top.sv ----
`timescale 1ns/1ps
`include "dsm_consts.svh"
module dsm_top import dsm_pkg::*; #(
  parameter int REF_W = 16,
  parameter int SELFTEST_CYC = `DSM_SELFTEST_CYC,
  parameter int GEN_HALF_CYC = `DSM_GEN_HALF_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire dsm_src_t SRC_SEL_IN,
  input wire dsm_mode_t MODE_SEL_IN,
  input wire dsm_shape_t SHAPE_SEL_IN,
  input wire dsm_cmd_t ECAT_CMD_IN,
  input wire dsm_cmd_t CAN_CMD_IN,
  input wire dsm_cmd_t IO_CMD_IN,
  input wire dsm_cmd_t LOCAL_CMD_IN,
  input wire logic LOCAL_SEND_IN,
  input wire logic [REF_W-1:0] ECAT_REF_IN,
  input wire logic [REF_W-1:0] CAN_REF_IN,
  input wire logic [REF_W-1:0] LOCAL_REF_IN,
  input wire logic [REF_W-1:0] AN_REF_IN,
  input wire logic [REF_W-1:0] AN_TLIM_IN,
  input wire logic TLIM_EN_IN,
  input wire logic [REF_W-1:0] GEN_AMP_IN,
  input wire logic [REF_W-1:0] GEN_OFS_IN,
  input wire logic SELFTEST_OK_IN,
  input wire logic FAULT_IN,
  input wire logic QSTOP_DONE_IN,
  input wire logic REACT_DONE_IN,
  output dsm_state_t STATE_OUT,
  output logic COMM_EN_OUT,
  output logic SEND_EN_OUT,
  output logic BRAKE_RELEASE_OUT,
  output logic LOW_PWR_OUT,
  output logic HIGH_PWR_OUT,
  output logic DRIVE_EN_OUT,
  output logic CFG_ALLOWED_OUT,
  output logic QSTOP_RUN_OUT,
  output logic REACT_RUN_OUT,
  output dsm_mode_t MODE_OUT,
  output logic SPEED_LOOP_OUT,
  output logic TORQUE_LOOP_OUT,
  output logic POS_LOOP_OUT,
  output logic [REF_W-1:0] REF_OUT,
  output logic [REF_W-1:0] TLIM_OUT,
  output logic TLIM_ACT_OUT
);
  if (REF_W < 4 || REF_W > 32) begin : g_bad_ref_w
    $error("REF_W out of range");
  end
  if (SELFTEST_CYC < 1) begin : g_bad_selftest
    $error("SELFTEST_CYC must be at least 1");
  end

  localparam int TW = $clog2(SELFTEST_CYC + 1);
  localparam logic [REF_W-1:0] REF_RST = REF_W'(`DSM_REF_RST);

  // fault pin synchroniser, three stages
  logic flt_s1_r;
  logic flt_s2_r;
  logic flt_s3_r;
  logic flt_r;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      flt_s1_r <= 1'b0;
      flt_s2_r <= 1'b0;
      flt_s3_r <= 1'b0;
      flt_r <= 1'b0;
    end else begin
      flt_s1_r <= FAULT_IN;
      flt_s2_r <= flt_s1_r;
      flt_s3_r <= flt_s2_r;
      if (flt_s2_r == flt_s3_r) flt_r <= flt_s3_r;
    end
  end

  // command and reference source selection
  dsm_cmd_t cmd;
  logic [REF_W-1:0] bus_ref;
  dsm_cmd_sel #(.REF_W(REF_W)) u_sel (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .src_in(SRC_SEL_IN),
    .ecat_cmd_in(ECAT_CMD_IN),
    .can_cmd_in(CAN_CMD_IN),
    .io_cmd_in(IO_CMD_IN),
    .local_cmd_in(LOCAL_CMD_IN),
    .local_send_in(LOCAL_SEND_IN),
    .ecat_ref_in(ECAT_REF_IN),
    .can_ref_in(CAN_REF_IN),
    .local_ref_in(LOCAL_REF_IN),
    .cmd_out(cmd),
    .send_en_out(SEND_EN_OUT),
    .ref_out(bus_ref)
  );

  // automaton
  dsm_state_t st_r;
  dsm_state_t st_nxt;
  logic [TW-1:0] tst_r;
  logic st_done_r;
  wire logic drive_on = (st_r == ST_OP_ENABLED) || (st_r == ST_QSTOP) ||
    (st_r == ST_FAULT_REACT);
  wire logic t4 = (st_r == ST_SWITCHED_ON) && (st_nxt == ST_OP_ENABLED);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_NOT_READY: begin
        if (st_done_r && SELFTEST_OK_IN) st_nxt = ST_SW_DISABLED;
      end
      ST_SW_DISABLED: begin
        if (cmd == CMD_SHUTDOWN) st_nxt = ST_READY;
      end
      ST_READY: begin
        if (cmd == CMD_SWITCH_ON) st_nxt = ST_SWITCHED_ON;
        else if (cmd == CMD_DISABLE_V || cmd == CMD_QUICK_STOP)
          st_nxt = ST_SW_DISABLED;
      end
      ST_SWITCHED_ON: begin
        if (cmd == CMD_ENABLE_OP) st_nxt = ST_OP_ENABLED;
        else if (cmd == CMD_SHUTDOWN) st_nxt = ST_READY;
        else if (cmd == CMD_DISABLE_V || cmd == CMD_QUICK_STOP)
          st_nxt = ST_SW_DISABLED;
      end
      ST_OP_ENABLED: begin
        if (cmd == CMD_DISABLE_OP) st_nxt = ST_SWITCHED_ON;
        else if (cmd == CMD_QUICK_STOP) st_nxt = ST_QSTOP;
        else if (cmd == CMD_SHUTDOWN) st_nxt = ST_READY;
        else if (cmd == CMD_DISABLE_V) st_nxt = ST_SW_DISABLED;
      end
      ST_QSTOP: begin
        if (QSTOP_DONE_IN || cmd == CMD_DISABLE_V) st_nxt = ST_SW_DISABLED;
      end
      ST_FAULT_REACT: begin
        if (REACT_DONE_IN) st_nxt = ST_FAULT;
      end
      ST_FAULT: begin
        if (cmd == CMD_FAULT_RESET && !flt_r) st_nxt = ST_SW_DISABLED;
      end
      default: st_nxt = ST_NOT_READY;
    endcase
    if (flt_r && st_r != ST_FAULT && st_r != ST_FAULT_REACT &&
        st_r != ST_NOT_READY)
      st_nxt = ST_FAULT_REACT;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_r <= ST_NOT_READY;
      tst_r <= '0;
      st_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (!st_done_r) tst_r <= tst_r + 1'b1;
      if (tst_r == TW'(SELFTEST_CYC - 1)) st_done_r <= 1'b1;
    end
  end

  // state outputs
  assign STATE_OUT = st_r;
  assign COMM_EN_OUT = (st_r != ST_NOT_READY);
  assign BRAKE_RELEASE_OUT = drive_on;
  assign LOW_PWR_OUT = 1'b1;
  assign HIGH_PWR_OUT = drive_on || (st_r == ST_SWITCHED_ON);
  assign DRIVE_EN_OUT = drive_on;
  assign CFG_ALLOWED_OUT = !drive_on;
  assign QSTOP_RUN_OUT = (st_r == ST_QSTOP);
  assign REACT_RUN_OUT = (st_r == ST_FAULT_REACT);

  // mode latch, updated only while disabled
  dsm_mode_t mode_r;
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_r <= MODE_AN_SPEED;
    end else if (!drive_on) begin
      mode_r <= MODE_SEL_IN;
    end
  end
  assign MODE_OUT = mode_r;
  wire logic is_speed = (mode_r == MODE_AN_SPEED) ||
    (mode_r == MODE_INT_SPEED) || (mode_r == MODE_CS_VEL);
  wire logic is_torque = (mode_r == MODE_AN_TORQUE) ||
    (mode_r == MODE_INT_TORQUE) || (mode_r == MODE_CS_TORQUE);
  assign SPEED_LOOP_OUT = drive_on && is_speed;
  assign TORQUE_LOOP_OUT = drive_on && is_torque;
  assign POS_LOOP_OUT = drive_on && (mode_r == MODE_CS_POS);

  // internal function generator
  logic [REF_W-1:0] gen_ref;
  wire logic gen_run = drive_on && !t4 &&
    ((mode_r == MODE_INT_SPEED) || (mode_r == MODE_INT_TORQUE));
  dsm_gen #(.REF_W(REF_W), .HALF_CYC(GEN_HALF_CYC)) u_gen (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .run_in(gen_run),
    .shape_in(SHAPE_SEL_IN),
    .amp_in(GEN_AMP_IN),
    .offset_in(GEN_OFS_IN),
    .ref_out(gen_ref)
  );

  // reference path
  logic [REF_W-1:0] ref_r;
  logic [REF_W-1:0] ref_nxt;
  logic [REF_W-1:0] tlim_r;
  logic tlim_act_r;
  always_comb begin
    ref_nxt = REF_RST;
    unique case (mode_r)
      MODE_AN_SPEED: ref_nxt = AN_REF_IN;
      MODE_AN_TORQUE: ref_nxt = AN_REF_IN;
      MODE_INT_SPEED, MODE_INT_TORQUE: ref_nxt = gen_ref;
      MODE_CS_POS, MODE_CS_VEL, MODE_CS_TORQUE: ref_nxt = bus_ref;
      default: ref_nxt = REF_RST;
    endcase
    if (!drive_on || t4) ref_nxt = REF_RST;
  end
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ref_r <= REF_RST;
      tlim_r <= REF_RST;
      tlim_act_r <= 1'b0;
    end else begin
      ref_r <= ref_nxt;
      tlim_act_r <= drive_on && (mode_r == MODE_AN_SPEED) && TLIM_EN_IN;
      tlim_r <= (mode_r == MODE_AN_SPEED && TLIM_EN_IN) ? AN_TLIM_IN :
        REF_RST;
    end
  end
  assign REF_OUT = ref_r;
  assign TLIM_OUT = tlim_r;
  assign TLIM_ACT_OUT = tlim_act_r;
endmodule : dsm_top

// ---- dsm_monitor.sv ----
`timescale 1ns/1ps
module dsm_monitor import dsm_pkg::*; (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire dsm_src_t SRC_SEL_IN,
  input wire dsm_cmd_t ECAT_CMD_IN,
  input wire logic FAULT_IN,
  input wire dsm_state_t STATE_OUT,
  input wire logic COMM_EN_OUT,
  input wire logic SEND_EN_OUT,
  input wire logic BRAKE_RELEASE_OUT,
  input wire logic LOW_PWR_OUT,
  input wire logic HIGH_PWR_OUT,
  input wire logic DRIVE_EN_OUT,
  input wire logic CFG_ALLOWED_OUT,
  input wire logic QSTOP_RUN_OUT
);
  logic [3:0] calm_r;
  wire logic calm = calm_r > 4'h6;
  wire logic act = STATE_OUT inside {ST_OP_ENABLED, ST_QSTOP, ST_FAULT_REACT};
  wire dsm_cmd_t ec = (SRC_SEL_IN == SRC_ECAT) ? ECAT_CMD_IN : CMD_NONE;
  // cycles since fault input last high
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) calm_r <= 4'h0;
    else if (FAULT_IN) calm_r <= 4'h0;
    else if (calm_r != 4'hf) calm_r <= calm_r + 4'h1;
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_init;
    $fell(RST_IN) |-> (STATE_OUT == ST_NOT_READY && !COMM_EN_OUT)[*2];
  endproperty
  a_init: assert property (p_init) else $error("early init");
  property p_comm; STATE_OUT == ST_SW_DISABLED |-> COMM_EN_OUT; endproperty
  a_comm: assert property (p_comm) else $error("comm off");
  property p_send; SEND_EN_OUT == (SRC_SEL_IN == SRC_LOCAL); endproperty
  a_send: assert property (p_send) else $error("send enable");
  property p_brake; BRAKE_RELEASE_OUT |-> act; endproperty
  a_brake: assert property (p_brake) else $error("brake released");
  property p_low; LOW_PWR_OUT; endproperty
  a_low: assert property (p_low) else $error("low power off");
  property p_high; STATE_OUT inside {[3:6]} |-> HIGH_PWR_OUT; endproperty
  a_high: assert property (p_high) else $error("high power off");
  property p_drive; DRIVE_EN_OUT == act; endproperty
  a_drive: assert property (p_drive) else $error("drive enable");
  property p_cfg; !DRIVE_EN_OUT |-> CFG_ALLOWED_OUT; endproperty
  a_cfg: assert property (p_cfg) else $error("config denied");
  property p_sdn;
    calm && STATE_OUT == ST_SW_DISABLED && ec == CMD_SHUTDOWN
      |=> STATE_OUT == ST_READY;
  endproperty
  a_sdn: assert property (p_sdn) else $error("shutdown");
  property p_swon;
    calm && STATE_OUT == ST_READY && ec == CMD_SWITCH_ON
      |=> STATE_OUT == ST_SWITCHED_ON && HIGH_PWR_OUT;
  endproperty
  a_swon: assert property (p_swon) else $error("switch on");
  property p_enop;
    calm && STATE_OUT == ST_SWITCHED_ON && ec == CMD_ENABLE_OP
      |=> STATE_OUT == ST_OP_ENABLED && DRIVE_EN_OUT;
  endproperty
  a_enop: assert property (p_enop) else $error("enable op");
  property p_disop;
    calm && STATE_OUT == ST_OP_ENABLED && ec == CMD_DISABLE_OP
      |=> STATE_OUT == ST_SWITCHED_ON && !DRIVE_EN_OUT;
  endproperty
  a_disop: assert property (p_disop) else $error("disable op");
  property p_qs;
    calm && STATE_OUT == ST_OP_ENABLED && ec == CMD_QUICK_STOP
      |=> STATE_OUT == ST_QSTOP && QSTOP_RUN_OUT;
  endproperty
  a_qs: assert property (p_qs) else $error("quick stop");
  property p_flt;
    $rose(FAULT_IN) && STATE_OUT inside {[1:5]}
      |-> ##[1:6] STATE_OUT == ST_FAULT_REACT;
  endproperty
  a_flt: assert property (p_flt) else $error("fault missed");
  property p_frst;
    FAULT_IN[*5] ##0 (STATE_OUT == ST_FAULT && ec == CMD_FAULT_RESET)
      |=> STATE_OUT == ST_FAULT;
  endproperty
  a_frst: assert property (p_frst) else $error("fault left");
endmodule : dsm_monitor

// ---- dsm_master.sv ----
`timescale 1ns/1ps
module dsm_master import dsm_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dsm_state_t state_in,
  input wire logic req_in,
  input wire dsm_cmd_t req_cmd_in,
  output dsm_cmd_t cmd_out
);
  // fault reset held until fault state is left
  wire logic hold = cmd_out == CMD_FAULT_RESET && state_in == ST_FAULT;
  wire dsm_cmd_t cmd_nxt = req_in ? req_cmd_in : hold ? cmd_out : CMD_NONE;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) cmd_out <= CMD_NONE;
    else cmd_out <= cmd_nxt;
  end
endmodule : dsm_master

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import dsm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, lsend = 1'b0, tlen = 1'b0, stok = 1'b1;
  logic flt = 1'b0, qdone = 1'b0, rdone = 1'b0, req = 1'b0;
  dsm_src_t src = SRC_ECAT;
  dsm_mode_t mode = MODE_CS_VEL, mode_o;
  dsm_shape_t shape = SHP_SQUARE;
  dsm_cmd_t can_cmd = CMD_NONE, io_cmd = CMD_NONE, lcmd = CMD_NONE;
  dsm_cmd_t rcmd = CMD_NONE, ecmd, c;
  dsm_state_t st, e;
  logic [15:0] eref = 16'h0, cref = 16'h0, lref = 16'h0, aref = 16'h0;
  logic [15:0] ref_o;
  logic comm, brk, highp, dren, qrun;
  logic react, spl, tql, psl, tlact;
  logic [15:0] tlim_o;
  int hi, lo;
  int failures = 0, samples_checked = 0;
  always #5 clk = ~clk;
  dsm_master u_master (.clk_in(clk), .rst_in(rst), .state_in(st),
    .req_in(req), .req_cmd_in(rcmd), .cmd_out(ecmd));
  dsm_top #(.SELFTEST_CYC(2), .GEN_HALF_CYC(4)) DUT (.CLK_IN(clk),
    .RST_IN(rst), .SRC_SEL_IN(src), .MODE_SEL_IN(mode), .SHAPE_SEL_IN(shape),
    .ECAT_CMD_IN(ecmd), .CAN_CMD_IN(can_cmd), .IO_CMD_IN(io_cmd),
    .LOCAL_CMD_IN(lcmd), .LOCAL_SEND_IN(lsend), .ECAT_REF_IN(eref),
    .CAN_REF_IN(cref), .LOCAL_REF_IN(lref), .AN_REF_IN(aref),
    .AN_TLIM_IN(cref), .TLIM_EN_IN(tlen), .GEN_AMP_IN(lref),
    .GEN_OFS_IN(aref), .SELFTEST_OK_IN(stok), .FAULT_IN(flt),
    .QSTOP_DONE_IN(qdone), .REACT_DONE_IN(rdone), .STATE_OUT(st),
    .COMM_EN_OUT(comm), .SEND_EN_OUT(), .BRAKE_RELEASE_OUT(brk),
    .LOW_PWR_OUT(), .HIGH_PWR_OUT(highp), .DRIVE_EN_OUT(dren),
    .CFG_ALLOWED_OUT(), .QSTOP_RUN_OUT(qrun), .REACT_RUN_OUT(react),
    .MODE_OUT(mode_o), .SPEED_LOOP_OUT(spl), .TORQUE_LOOP_OUT(tql),
    .POS_LOOP_OUT(psl), .REF_OUT(ref_o), .TLIM_OUT(tlim_o),
    .TLIM_ACT_OUT(tlact));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk_v(input logic [15:0] g, input logic [15:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("Error at %0t: got %h exp %h", $time, g, x);
    end
  endtask : chk_v
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic send(input dsm_cmd_t k);
    req = 1'b1;
    rcmd = k;
    cyc(1);
    req = 1'b0;
    cyc(3);
  endtask : send
  function automatic dsm_state_t nx(dsm_state_t s, dsm_cmd_t k);
    case (s)
      ST_SW_DISABLED: return k == CMD_SHUTDOWN ? ST_READY : s;
      ST_READY: return k == CMD_SWITCH_ON ? ST_SWITCHED_ON :
        k inside {CMD_DISABLE_V, CMD_QUICK_STOP} ? ST_SW_DISABLED : s;
      ST_SWITCHED_ON: return k == CMD_ENABLE_OP ? ST_OP_ENABLED :
        k == CMD_SHUTDOWN ? ST_READY :
        k inside {CMD_DISABLE_V, CMD_QUICK_STOP} ? ST_SW_DISABLED : s;
      ST_OP_ENABLED: return k == CMD_DISABLE_OP ? ST_SWITCHED_ON :
        k == CMD_QUICK_STOP ? ST_QSTOP : k == CMD_SHUTDOWN ? ST_READY :
        k == CMD_DISABLE_V ? ST_SW_DISABLED : s;
      ST_QSTOP: return k == CMD_DISABLE_V ? ST_SW_DISABLED : s;
      default: return s;
    endcase
  endfunction : nx
  function automatic logic [2:0] loops(dsm_mode_t m);
    case (m)
      MODE_AN_SPEED, MODE_INT_SPEED, MODE_CS_VEL: return 3'h4;
      MODE_AN_TORQUE, MODE_INT_TORQUE, MODE_CS_TORQUE: return 3'h2;
      MODE_CS_POS: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction : loops
  function automatic logic [15:0] ref_exp(dsm_mode_t m);
    if (m inside {MODE_AN_SPEED, MODE_AN_TORQUE}) return aref;
    if (m inside {MODE_INT_SPEED, MODE_INT_TORQUE}) return 16'(aref + lref);
    return eref;
  endfunction : ref_exp
  initial begin
    void'($urandom(76));
    cyc(3);
    rst = 1'b0;
    chk_v(st, ST_NOT_READY);
    for (int i = 0; i < 50 && st !== ST_SW_DISABLED; i++) cyc(1);
    chk_v(st, ST_SW_DISABLED);
    if (st !== ST_SW_DISABLED) tally_and_finish();
    chk_v(comm, 1'b1);
    $display("test init done");
    send(CMD_SHUTDOWN);
    chk_v(st, ST_READY);
    send(CMD_SWITCH_ON);
    chk_v({st, highp}, {ST_SWITCHED_ON, 1'b1});
    send(CMD_ENABLE_OP);
    chk_v({st, dren, brk}, {ST_OP_ENABLED, 2'b11});
    eref = 16'($urandom);
    can_cmd = CMD_DISABLE_V;
    cyc(3);
    chk_v(ref_o, eref);
    chk_v(st, ST_OP_ENABLED);
    send(CMD_SWITCH_ON);
    chk_v(st, ST_OP_ENABLED);
    mode = MODE_CS_POS;
    cyc(2);
    chk_v(mode_o, MODE_CS_VEL);
    send(CMD_DISABLE_OP);
    chk_v({st, dren}, {ST_SWITCHED_ON, 1'b0});
    chk_v(mode_o, MODE_CS_POS);
    send(CMD_ENABLE_OP);
    send(CMD_QUICK_STOP);
    chk_v({st, qrun}, {ST_QSTOP, 1'b1});
    qdone = 1'b1;
    cyc(3);
    qdone = 1'b0;
    chk_v(st, ST_SW_DISABLED);
    $display("test walk done");
    src = SRC_LOCAL;
    lcmd = CMD_SHUTDOWN;
    cyc(3);
    chk_v(st, ST_SW_DISABLED);
    lsend = 1'b1;
    cyc(3);
    lsend = 1'b0;
    chk_v(st, ST_READY);
    src = SRC_ECAT;
    lcmd = CMD_DISABLE_V;
    lsend = 1'b1;
    cyc(3);
    lsend = 1'b0;
    chk_v(st, ST_READY);
    $display("test local done");
    flt = 1'b1;
    cyc(8);
    chk_v({st, dren, react}, {ST_FAULT_REACT, 2'b11});
    rdone = 1'b1;
    cyc(3);
    rdone = 1'b0;
    send(CMD_FAULT_RESET);
    cyc(4);
    chk_v(st, ST_FAULT);
    flt = 1'b0;
    cyc(8);
    chk_v({st, dren}, {ST_SW_DISABLED, 1'b0});
    $display("test fault done");
    src = SRC_CAN;
    can_cmd = CMD_SHUTDOWN;
    cyc(2);
    chk_v(st, ST_READY);
    can_cmd = CMD_NONE;
    src = SRC_ANALOG;
    io_cmd = CMD_DISABLE_V;
    cyc(2);
    chk_v(st, ST_SW_DISABLED);
    io_cmd = CMD_NONE;
    src = SRC_ECAT;
    $display("test source done");
    tlen = 1'b1;
    for (int k = 0; k < 7; k++) begin
      mode = dsm_mode_t'(k);
      shape = (k == 3) ? SHP_SQUARE : SHP_JOG;
      {eref, cref} = $urandom;
      aref = 16'($urandom);
      lref = 16'($urandom) | 16'h0001;
      send(CMD_SHUTDOWN);
      send(CMD_SWITCH_ON);
      send(CMD_ENABLE_OP);
      chk_v(mode_o, mode);
      chk_v({spl, tql, psl}, loops(mode));
      chk_v(tlim_o, (k == 0) ? cref : 16'h0000);
      chk_v(tlact, k == 0);
      if (k == 3) begin
        hi = 0;
        lo = 0;
        for (int j = 0; j < 8; j++) begin
          hi += int'(ref_o === 16'(aref + lref));
          lo += int'(ref_o === aref);
          cyc(1);
        end
        chk_v({8'(hi), 8'(lo)}, 16'h0404);
      end else begin
        chk_v(ref_o, ref_exp(mode));
      end
      send(CMD_DISABLE_V);
      chk_v({st, spl, tql, psl}, {ST_SW_DISABLED, 3'h0});
    end
    tlen = 1'b0;
    $display("test mode done");
    e = ST_SW_DISABLED;
    can_cmd = CMD_SWITCH_ON;
    for (int i = 0; i < 60; i++) begin
      c = dsm_cmd_t'($urandom_range(0, 7));
      {eref, cref, lref, aref} = {$urandom, $urandom};
      e = nx(e, c);
      send(c);
      chk_v(st, e);
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule : tb
bind dsm_top dsm_monitor u_mon (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .SRC_SEL_IN(SRC_SEL_IN), .ECAT_CMD_IN(ECAT_CMD_IN), .FAULT_IN(FAULT_IN),
  .STATE_OUT(STATE_OUT), .COMM_EN_OUT(COMM_EN_OUT),
  .SEND_EN_OUT(SEND_EN_OUT), .BRAKE_RELEASE_OUT(BRAKE_RELEASE_OUT),
  .LOW_PWR_OUT(LOW_PWR_OUT), .HIGH_PWR_OUT(HIGH_PWR_OUT),
  .DRIVE_EN_OUT(DRIVE_EN_OUT), .CFG_ALLOWED_OUT(CFG_ALLOWED_OUT),
  .QSTOP_RUN_OUT(QSTOP_RUN_OUT));
